// >>> logic/smc_consts.vh
// constants for the stop-mode controller: register offsets, field positions, states
// assumes a 32-bit axi4-lite slave with word-aligned byte addresses
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
// register byte offsets
`define SMC_OFF_CTRL 4'h0
`define SMC_OFF_STAT 4'h4
`define SMC_OFF_WAKE 4'h8
// control register fields
`define SMC_CTL_STOPEN 0
`define SMC_CTL_DEEPSEL 1
`define SMC_CTL_VMEN 2
`define SMC_CTL_VMSTOP 3
`define SMC_CTL_OSCKEEP 4
`define SMC_CTL_ADCASYNC 5
`define SMC_CTL_LVRST 6
`define SMC_CTL_RATE_LO 8
`define SMC_CTL_RATE_HI 10
`define SMC_CTL_RESET 32'h0000_0000
// status register fields
`define SMC_ST_DEEPFLAG 0
`define SMC_ST_MODE_LO 1
`define SMC_ST_MODE_HI 2
`define SMC_ST_DBGHALT 3
// wake register fields (write one to act)
`define SMC_WK_RELACK 0
// stop states
`define SMC_ST_RUN 2'h0
`define SMC_ST_LIGHT 2'h1
`define SMC_ST_DEEP 2'h2
// debug status codes
`define SMC_DBG_OK 2'h0
`define SMC_DBG_STOPPED 2'h1
`define SMC_DBG_REFUSED 2'h2
// axi responses
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2
`endif

// >>> logic/smc_stop_mode_controller.v
// stop-mode resolution and domain gating, with an axi4-lite register slave
// assumes cpu stop strobe, wake events and debug commands arrive on clk_sys
// Summary of operation
// - debug entry enabled keeps debug clock in stop
// - debug entry enabled keeps regulator fully regulating
// - deep stop with debug enabled becomes light
// - stopped debug refuses commands, status reports stop
// - debug halt wakes into halt if enabled
// - debug stop: clockgen, regulator on, rest standby
// - low voltage raises interrupt or reset
// - monitor and stop enable keep regulator active
// - deep stop with monitor armed becomes light
// - monitor stop: clockgen off, regulator on
// - peripheral clocks gated in every stop mode
// - deep powers off blocks, light standby them
// - converter on in light only with async clock, monitor
// - clockgen runs in light only with keepalive or debug entry
// - wake timer runs only with nonzero rate
// - stop disabled: no stop, illegal-opcode reset
// - deep wake flag, pin latch until ack
// - zero rate disables timer and its source
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_stop_mode_controller (
  input wire clk_sys, // system clock
  input wire reset_n, // async reset, active low
  input wire clk_en, // freezes all state when low
  input wire stop_exec, // cpu executes stop, one-cycle pulse
  input wire wake_evt, // interrupt, timer or pin wake pulse
  input wire dbg_entry_enable, // debug entry enable level
  input wire dbg_cmd_valid, // debug command pulse
  input wire dbg_cmd_halt, // command is debug halt
  input wire dbg_cmd_status, // command is memory access with status
  input wire low_voltage_raw, // supply below threshold, async pin
  output reg dbg_cmd_accept_ff, // command allowed to execute
  output reg [1:0] dbg_status_ff, // status code returned
  output reg dbg_halt_mode_ff, // device entered debug halt
  output reg illegal_reset_ff, // illegal-opcode reset pulse
  output reg lv_irq_ff, // low-voltage interrupt level
  output reg lv_reset_ff, // low-voltage reset level
  output reg dbg_clk_en_ff, // debug logic clock enable
  output reg periph_clk_en_ff, // peripheral clocks enable
  output reg reg_full_ff, // regulator full regulation
  output reg clkgen_on_ff, // clock generator running
  output reg core_power_ff, // cpu, flash, ports, serial powered
  output reg core_standby_ff, // cpu etc. in standby
  output reg adc_on_ff, // converter operational
  output reg wake_timer_on_ff, // periodic wake timer and source on
  output reg pin_hold_ff, // pin states held
  output reg [1:0] stop_mode_ff, // resolved mode
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready_ff, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready_ff, // write data ready
  output reg [1:0] s_axi_bresp_ff, // write response
  output reg s_axi_bvalid_ff, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready_ff, // read address ready
  output reg [31:0] s_axi_rdata_ff, // read data
  output reg [1:0] s_axi_rresp_ff, // read response
  output reg s_axi_rvalid_ff, // read response valid
  input wire s_axi_rready // read response ready
);

  parameter RATE_W = 3; // wake-timer rate field width

  reg [31:0] ctrl_ff; // control register
  reg deep_flag_ff; // deep-stop wake flag
  reg lv_s1_ff, lv_s2_ff, lv_s3_ff; // low-voltage synchroniser
  reg lv_ff; // filtered low-voltage level
  reg [3:0] awaddr_ff; // captured write address
  reg [31:0] wdata_ff; // captured write data
  reg [3:0] wstrb_ff; // captured strobes
  reg aw_got_ff, w_got_ff; // halves of a write received

  // control fields
  wire stop_en = ctrl_ff[`SMC_CTL_STOPEN];
  wire deep_sel = ctrl_ff[`SMC_CTL_DEEPSEL];
  wire vm_en = ctrl_ff[`SMC_CTL_VMEN];
  wire vm_stop = ctrl_ff[`SMC_CTL_VMSTOP];
  wire osc_keep = ctrl_ff[`SMC_CTL_OSCKEEP];
  wire adc_async = ctrl_ff[`SMC_CTL_ADCASYNC];
  wire lv_rst_sel = ctrl_ff[`SMC_CTL_LVRST];
  wire [RATE_W-1:0] rate = ctrl_ff[`SMC_CTL_RATE_HI:`SMC_CTL_RATE_LO];

  wire vm_armed = vm_en & vm_stop; // monitor armed for stop
  wire stopped = (stop_mode_ff != `SMC_ST_RUN);
  wire halt_wake = stopped & dbg_cmd_valid & dbg_cmd_halt & dbg_entry_enable;

  // entry decision: deep only when neither debug nor monitor forces light
  wire go_deep = deep_sel & ~dbg_entry_enable & ~vm_armed;
  wire [1:0] entry_mode = go_deep ? `SMC_ST_DEEP : `SMC_ST_LIGHT;

  // register write path: both halves gathered, then committed
  wire do_write = aw_got_ff & w_got_ff & ~s_axi_bvalid_ff;
  wire wr_ctrl = do_write & ({awaddr_ff[3:2], 2'h0} == `SMC_OFF_CTRL);
  wire wr_wake = do_write & ({awaddr_ff[3:2], 2'h0} == `SMC_OFF_WAKE);
  wire rel_ack = wr_wake & wstrb_ff[0] & wdata_ff[`SMC_WK_RELACK];

  wire [31:0] stat_word = {28'h0000000, dbg_halt_mode_ff, stop_mode_ff, deep_flag_ff};

  // low-voltage pin synchroniser; first stage feeds only the second
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lv_s1_ff <= 1'b0;
      lv_s2_ff <= 1'b0;
      lv_s3_ff <= 1'b0;
      lv_ff <= 1'b0;
    end else if (clk_en) begin
      lv_s1_ff <= low_voltage_raw;
      lv_s2_ff <= lv_s1_ff;
      lv_s3_ff <= lv_s2_ff;
      if (lv_s2_ff == lv_s3_ff) begin // change counts once stages agree
        lv_ff <= lv_s3_ff;
      end
    end
  end

  // low-voltage response, gated by the monitor enable
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lv_irq_ff <= 1'b0;
      lv_reset_ff <= 1'b0;
    end else if (clk_en) begin
      lv_irq_ff <= lv_ff & vm_en & ~lv_rst_sel;
      lv_reset_ff <= lv_ff & vm_en & lv_rst_sel;
    end
  end

  // stop state machine: mode fixed at entry, cleared on wake
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stop_mode_ff <= `SMC_ST_RUN;
      illegal_reset_ff <= 1'b0;
      dbg_halt_mode_ff <= 1'b0;
    end else if (clk_en) begin
      illegal_reset_ff <= 1'b0;
      case (stop_mode_ff)
        `SMC_ST_RUN: begin
          if (stop_exec && !stop_en) begin
            illegal_reset_ff <= 1'b1;
          end else if (stop_exec) begin
            stop_mode_ff <= entry_mode;
            dbg_halt_mode_ff <= 1'b0;
          end
        end
        `SMC_ST_LIGHT, `SMC_ST_DEEP: begin
          if (halt_wake) begin
            stop_mode_ff <= `SMC_ST_RUN;
            dbg_halt_mode_ff <= 1'b1;
          end else if (wake_evt) begin
            stop_mode_ff <= `SMC_ST_RUN;
          end
        end
        default: begin
          stop_mode_ff <= `SMC_ST_RUN; // unused code recovers to run
        end
      endcase
    end
  end

  // deep-stop wake flag; a new deep wake beats a simultaneous ack
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deep_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (stop_mode_ff == `SMC_ST_DEEP && (wake_evt || halt_wake)) begin
        deep_flag_ff <= 1'b1;
      end else if (rel_ack) begin
        deep_flag_ff <= 1'b0;
      end
    end
  end

  // domain gating from the resolved mode
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dbg_clk_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      reg_full_ff <= 1'b1;
      clkgen_on_ff <= 1'b1;
      core_power_ff <= 1'b1;
      core_standby_ff <= 1'b0;
      adc_on_ff <= 1'b1;
      wake_timer_on_ff <= 1'b0;
      pin_hold_ff <= 1'b0;
    end else if (clk_en) begin
      case (stop_mode_ff)
        `SMC_ST_RUN: begin
          dbg_clk_en_ff <= 1'b1;
          periph_clk_en_ff <= 1'b1;
          reg_full_ff <= 1'b1;
          clkgen_on_ff <= 1'b1;
          core_power_ff <= 1'b1;
          core_standby_ff <= 1'b0;
          adc_on_ff <= 1'b1;
          wake_timer_on_ff <= (rate != {RATE_W{1'b0}});
          pin_hold_ff <= deep_flag_ff;
        end
        `SMC_ST_LIGHT: begin
          dbg_clk_en_ff <= dbg_entry_enable;
          periph_clk_en_ff <= 1'b0;
          reg_full_ff <= dbg_entry_enable | vm_armed;
          clkgen_on_ff <= dbg_entry_enable | (osc_keep & ~vm_armed);
          core_power_ff <= 1'b1;
          core_standby_ff <= 1'b1;
          adc_on_ff <= adc_async & vm_en;
          wake_timer_on_ff <= (rate != {RATE_W{1'b0}});
          pin_hold_ff <= 1'b1;
        end
        `SMC_ST_DEEP: begin
          dbg_clk_en_ff <= 1'b0;
          periph_clk_en_ff <= 1'b0;
          reg_full_ff <= 1'b0;
          clkgen_on_ff <= 1'b0;
          core_power_ff <= 1'b0;
          core_standby_ff <= 1'b0;
          adc_on_ff <= 1'b0;
          wake_timer_on_ff <= (rate != {RATE_W{1'b0}});
          pin_hold_ff <= 1'b1;
        end
        default: begin
          periph_clk_en_ff <= 1'b1;
        end
      endcase
    end
  end

  // debug command filter while stopped
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dbg_cmd_accept_ff <= 1'b0;
      dbg_status_ff <= `SMC_DBG_OK;
    end else if (clk_en) begin
      dbg_cmd_accept_ff <= 1'b0;
      if (dbg_cmd_valid) begin
        if (!stopped) begin
          dbg_cmd_accept_ff <= 1'b1;
          dbg_status_ff <= `SMC_DBG_OK;
        end else if (halt_wake) begin
          dbg_cmd_accept_ff <= 1'b1;
          dbg_status_ff <= `SMC_DBG_OK;
        end else if (dbg_cmd_status) begin
          dbg_status_ff <= `SMC_DBG_STOPPED;
        end else begin
          dbg_status_ff <= `SMC_DBG_REFUSED;
        end
      end
    end
  end

  // axi write channel: address and data taken in either order
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready_ff <= 1'b1;
      s_axi_wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff <= `SMC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
        s_axi_awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
        s_axi_wready_ff <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_ff <= 1'b1;
        // status is read-only; unmapped offsets answer slverr
        s_axi_bresp_ff <= (wr_ctrl || wr_wake) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end
      if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_awready_ff <= 1'b1;
        s_axi_wready_ff <= 1'b1;
      end
    end
  end

  // control register, byte-lane writes
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `SMC_CTL_RESET;
    end else if (clk_en && wr_ctrl) begin
      if (wstrb_ff[0]) begin
        ctrl_ff[6:0] <= wdata_ff[6:0];
      end
      if (wstrb_ff[1]) begin
        ctrl_ff[10:8] <= wdata_ff[10:8];
      end
    end
  end

  // axi read channel; one read at a time, unmapped answers slverr
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready_ff <= 1'b1;
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff <= 32'h0000_0000;
      s_axi_rresp_ff <= `SMC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready_ff) begin
        s_axi_arready_ff <= 1'b0;
        s_axi_rvalid_ff <= 1'b1;
        s_axi_rresp_ff <= `SMC_RESP_OKAY;
        // word index only; byte-offset bits of the address are ignored
        case ({s_axi_araddr[3:2], 2'h0})
          `SMC_OFF_CTRL: s_axi_rdata_ff <= ctrl_ff & 32'h0000_077F;
          `SMC_OFF_STAT: s_axi_rdata_ff <= stat_word;
          `SMC_OFF_WAKE: s_axi_rdata_ff <= 32'h0000_0000;
          default: begin
            s_axi_rdata_ff <= 32'h0000_0000;
            s_axi_rresp_ff <= `SMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_ff && s_axi_rready) begin
        s_axi_rvalid_ff <= 1'b0;
        s_axi_arready_ff <= 1'b1;
      end
    end
  end

endmodule

// >>> verification/smc_stop_monitor.sv
// checker for the stop-mode controller ports
// assumes it is bound onto the design top, one clock domain
`timescale 1ns/1ps
module smc_mon (
  input wire clk_sys, // clock
  input wire reset_n, // reset, low
  input wire clk_en, // run enable
  input wire stop_exec, // stop strobe
  input wire wake_evt, // wake pulse
  input wire dbg_entry_enable, // debug entry
  input wire dbg_cmd_valid, // cmd strobe
  input wire dbg_cmd_halt, // halt cmd
  input wire dbg_cmd_status, // status cmd
  input wire dbg_cmd_accept_ff, // accepted
  input wire [1:0] dbg_status_ff, // status code
  input wire dbg_halt_mode_ff, // halted
  input wire illegal_reset_ff, // bad stop
  input wire dbg_clk_en_ff, // debug clock
  input wire periph_clk_en_ff, // periph clock
  input wire reg_full_ff, // regulator
  input wire clkgen_on_ff, // clock gen
  input wire core_power_ff, // core power
  input wire adc_on_ff, // converter
  input wire pin_hold_ff, // pins held
  input wire [1:0] stop_mode_ff // mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // stop strobe from run with debug entry armed
  wire go = stop_exec && clk_en && stop_mode_ff == 2'h0 && dbg_entry_enable;
  wire stp = clk_en && stop_mode_ff != 2'h0; // stopped, clocked
  wire cmd = dbg_cmd_valid && stp && !wake_evt; // cmd while stopped
  a_illegal_no_stop: assert property (illegal_reset_ff |-> stop_mode_ff == 2'h0)
    else $error("stop taken with illegal reset");
  a_dbg_no_deep: assert property (go |=> stop_mode_ff != 2'h2)
    else $error("deep stop with debug entry");
  a_dbg_clk_kept: assert property (go ##1 stp |=> dbg_clk_en_ff && reg_full_ff && clkgen_on_ff)
    else $error("debug stop gating wrong");
  a_periph_gated: assert property (stp |=> !periph_clk_en_ff)
    else $error("peripheral clock running in stop");
  a_deep_off: assert property (clk_en && stop_mode_ff == 2'h2 |=> !core_power_ff && !clkgen_on_ff
    && !adc_on_ff && !reg_full_ff && pin_hold_ff)
    else $error("deep stop domains wrong");
  a_stop_status_err: assert property (cmd && dbg_cmd_status && !dbg_cmd_halt |=>
    dbg_status_ff == 2'h1 && !dbg_cmd_accept_ff)
    else $error("status cmd not refused in stop");
  a_halt_wakes: assert property (cmd && dbg_cmd_halt && dbg_entry_enable |=>
    stop_mode_ff == 2'h0 && dbg_halt_mode_ff && dbg_cmd_accept_ff)
    else $error("halt cmd did not wake");
  a_mode_held: assert property (stop_mode_ff != 2'h0 && !wake_evt && !(dbg_cmd_valid && dbg_cmd_halt)
    |=> $stable(stop_mode_ff))
    else $error("mode changed without wake");
  a_deep_wake_latch: assert property (clk_en && stop_mode_ff == 2'h2 && wake_evt |=>
    stop_mode_ff == 2'h0 ##1 pin_hold_ff)
    else $error("pins not held after deep wake");
endmodule
bind smc_stop_mode_controller smc_mon u_mon (.clk_sys, .reset_n, .clk_en, .stop_exec, .wake_evt,
  .dbg_entry_enable, .dbg_cmd_valid, .dbg_cmd_halt, .dbg_cmd_status, .dbg_cmd_accept_ff,
  .dbg_status_ff, .dbg_halt_mode_ff, .illegal_reset_ff, .dbg_clk_en_ff, .periph_clk_en_ff,
  .reg_full_ff, .clkgen_on_ff, .core_power_ff, .adc_on_ff, .pin_hold_ff, .stop_mode_ff);

// >>> verification/smc_cpu_model.sv
// model of the cpu core and debug controller strobes
// assumes calls start right after a rising clk_sys edge
`timescale 1ns/1ps
module smc_cpu_model (
  input wire clk_sys, // clock
  output logic stop_exec, // stop strobe
  output logic wake_evt, // wake pulse
  output logic dbg_cmd_valid, // cmd strobe
  output logic dbg_cmd_halt, // halt qualifier
  output logic dbg_cmd_status // status qualifier
);
  initial {stop_exec, wake_evt, dbg_cmd_valid, dbg_cmd_halt, dbg_cmd_status} = 5'h00;
  // one-cycle strobe; k is {stop, wake, cmd}
  // qualifiers flip once released so stale values never look valid
  task automatic strobe(input logic [2:0] k, input logic h, input logic s);
    @(posedge clk_sys);
    {stop_exec, wake_evt, dbg_cmd_valid} <= k;
    {dbg_cmd_halt, dbg_cmd_status} <= {h, s};
    @(posedge clk_sys);
    {stop_exec, wake_evt, dbg_cmd_valid} <= 3'h0;
    {dbg_cmd_halt, dbg_cmd_status} <= {~h, ~s};
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the stop-mode controller
// assumes the cpu model and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1; // clock, reset, run
  logic dbg_entry_enable = 1'b0, low_voltage_raw = 1'b0; // levels
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF; // bus
  logic [31:0] s_axi_wdata = 32'h0000_0000; // write data
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, snap = 1'b0; // read, sample
  wire stop_exec, wake_evt, dbg_cmd_valid, dbg_cmd_halt, dbg_cmd_status; // cpu
  wire dbg_cmd_accept_ff, dbg_halt_mode_ff, illegal_reset_ff, lv_irq_ff, lv_reset_ff;
  wire dbg_clk_en_ff, periph_clk_en_ff, reg_full_ff, clkgen_on_ff, core_power_ff;
  wire core_standby_ff, adc_on_ff, wake_timer_on_ff, pin_hold_ff; // gating
  wire [1:0] dbg_status_ff, stop_mode_ff, s_axi_bresp_ff, s_axi_rresp_ff; // codes
  wire s_axi_awready_ff, s_axi_wready_ff, s_axi_bvalid_ff, s_axi_arready_ff, s_axi_rvalid_ff;
  wire [31:0] s_axi_rdata_ff; // read data
  logic [65:0] notes[$]; // read resp, mask, expected
  logic [65:0] nt;
  logic [31:0] got, seed = 32'h0000_F5D6, c;
  logic dbg, deep, halt;
  int mismatches = 0, cmp_count = 0;
  // output levels packed for one compare
  wire [31:0] lv = {18'h0, illegal_reset_ff, core_standby_ff, lv_irq_ff, lv_reset_ff,
    dbg_cmd_accept_ff, dbg_status_ff,
    periph_clk_en_ff, clkgen_on_ff, reg_full_ff, adc_on_ff, wake_timer_on_ff, pin_hold_ff,
    core_power_ff};
  smc_stop_mode_controller DUT (.clk_sys, .reset_n, .clk_en, .stop_exec, .wake_evt,
    .dbg_entry_enable, .dbg_cmd_valid, .dbg_cmd_halt, .dbg_cmd_status, .low_voltage_raw,
    .dbg_cmd_accept_ff, .dbg_status_ff, .dbg_halt_mode_ff, .illegal_reset_ff, .lv_irq_ff,
    .lv_reset_ff, .dbg_clk_en_ff, .periph_clk_en_ff, .reg_full_ff, .clkgen_on_ff,
    .core_power_ff, .core_standby_ff, .adc_on_ff, .wake_timer_on_ff, .pin_hold_ff,
    .stop_mode_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready_ff, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready_ff, .s_axi_bresp_ff, .s_axi_bvalid_ff,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready_ff, .s_axi_rdata_ff,
    .s_axi_rresp_ff, .s_axi_rvalid_ff, .s_axi_rready);
  smc_cpu_model u_cpu (.clk_sys, .stop_exec, .wake_evt, .dbg_cmd_valid, .dbg_cmd_halt,
    .dbg_cmd_status);
  always #2 clk_sys = ~clk_sys;
  // watcher: pops the oldest note whenever a result shows
  always @(posedge clk_sys) begin
    if ((s_axi_rvalid_ff && s_axi_rready) || (s_axi_bvalid_ff && s_axi_bready) || snap) begin
      got = snap ? lv : s_axi_rvalid_ff ? s_axi_rdata_ff : {30'h0, s_axi_bresp_ff};
      nt = notes.pop_front();
      cmp_count++;
      if (((got & nt[63:32]) !== (nt[31:0] & nt[63:32]))
          || (!snap && s_axi_rvalid_ff && s_axi_rresp_ff !== nt[65:64])) begin
        mismatches++;
        $display("unexpected at %0t: got %h want %h", $time, got, nt[31:0]);
      end
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // level sample taken by the watcher one edge later
  task automatic chk(input logic [31:0] m, input logic [31:0] e);
    notes.push_back({2'h0, m, e});
    snap <= 1'b1;
    @(posedge clk_sys);
    snap <= 1'b0;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back({2'h0, 32'h3, 30'h0, r});
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready_ff) s_axi_awvalid <= 1'b0;
      if (s_axi_wready_ff) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid_ff);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    notes.push_back({r, 32'hFFFF_FFFF, e});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready_ff) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid_ff);
    s_axi_rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    wr(4'h4, 32'hFFFF_FFFF, 2'h2); // status is read-only
    rd(4'hC, 32'h0000_0000, 2'h2); // unmapped
    wr(4'h0, 32'h0000_0002, 2'h0); // deep picked, stop not allowed
    u_cpu.strobe(3'h4, 1'b0, 1'b0);
    chk(32'h2000, 32'h2000);
    rd(4'h4, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      c = seed | 32'h0000_0001;
      dbg = seed[16];
      halt = dbg & seed[17];
      deep = c[1] && !dbg && !(c[2] && c[3]);
      wr(4'h0, c, 2'h0);
      rd(4'h0, c & 32'h0000_077F);
      dbg_entry_enable <= dbg;
      u_cpu.strobe(3'h4, 1'b0, 1'b0);
      repeat (3) @(posedge clk_sys);
      chk(32'h307F, {18'h0, 1'b0, !deep, 6'h0, !deep & (dbg | (c[4] & !(c[2] & c[3]))),
        !deep & (dbg | (c[2] & c[3])), !deep & c[5] & c[2], |c[10:8], 1'b1,
        !deep});
      rd(4'h4, {29'h0, deep ? 2'h2 : 2'h1, 1'b0});
      if (dbg) begin
        u_cpu.strobe(3'h1, 1'b0, 1'b1);
        chk(32'h380, 32'h080);
        u_cpu.strobe(3'h1, 1'b0, 1'b0);
        chk(32'h380, 32'h100);
      end
      if (!dbg) u_cpu.strobe(3'h1, 1'b1, 1'b0);
      if (halt) begin
        u_cpu.strobe(3'h1, 1'b1, 1'b0);
        chk(32'h200, 32'h200);
        rd(4'h4, 32'h0000_0008);
      end else begin
        clk_en <= 1'b0; // frozen block must ignore a wake
        u_cpu.strobe(3'h2, 1'b0, 1'b0);
        clk_en <= 1'b1;
        rd(4'h4, {29'h0, deep ? 2'h2 : 2'h1, 1'b0});
        u_cpu.strobe(3'h2, 1'b0, 1'b0);
        rd(4'h4, {31'h0, deep});
        if (deep) wr(4'h8, 32'h0000_0001, 2'h0);
        rd(4'h4, 32'h0000_0000);
      end
      low_voltage_raw <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(32'hC00, {20'h0, c[2] & !c[6], c[2] & c[6], 10'h0});
      low_voltage_raw <= 1'b0;
    end
    summarize();
  end
endmodule
